// ==== pkg/sync_slave_defs.svh ====
// register map, field positions and reset values of the serial port
`ifndef SYNC_SLAVE_DEFS_SVH
`define SYNC_SLAVE_DEFS_SVH

// =====================================================================
// register indices, byte address is index times four
`define TXCS_IDX    12'h11e
`define RCCS_IDX    12'h11d
`define RXDATA_IDX  12'h119
`define TXDATA_IDX  12'h11a
`define IRQEN_IDX   12'h120
`define REG_ADDR(i) {i, 2'b00}
`define ADDR_HI_ZERO 18'h00000

// =====================================================================
// transmit control/status fields
`define TXCS_CLKSRC 7
`define TXCS_NINE   6
`define TXCS_TXON   5
`define TXCS_SYNC   4
`define TXCS_BRK    3
`define TXCS_FAST   2
`define TXCS_EMPTY  1
`define TXCS_NINTH  0
`define TXCS_RST    8'h02
`define TXCS_WMASK  8'hfd

// =====================================================================
// receive control/status fields
`define RCCS_PORT   7
`define RCCS_NINE   6
`define RCCS_ONCE   5
`define RCCS_CONT   4
`define RCCS_RST    8'h00
`define RCCS_WMASK  8'hf0

// =====================================================================
// interrupt enable and flag register
`define IRQEN_TXIE  0
`define IRQEN_RCIE  1
`define IRQEN_PERI  2
`define IRQEN_RST   8'h00
`define IRQEN_WMASK 8'h07

// =====================================================================
// character lengths
`define BITS8       4'h8
`define BITS9       4'h9

`endif

// ==== pkg/sync_slave_pkg.sv ====
// types shared by the synchronous slave serial port
package sync_slave_pkg;

   // =================================================================
   // one received or transmitted character, ninth bit on top
   typedef logic [8:0] char_t;

   // =================================================================
   // operating mode decoded from the control bits
   typedef enum {
      PORT_OFF,
      PORT_OTHER,
      PORT_SLAVE_TX,
      PORT_SLAVE_RX
   } port_mode_t;

endpackage : sync_slave_pkg

// ==== verilog/sync_serial_slave_port.sv ====
// synchronous slave serial port with its ahb-lite register slave
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ns
`include "sync_slave_defs.svh"
// =====================================================================
// How it works
// RULE1 - slave when sync set, source clear, enabled
// RULE2 - any receive enable set means receiver
// RULE3 - first write loads shifter, second waits
// RULE4 - after last bit reload, then set flag
// RULE5 - flag with both enables raises wake request
// RULE6 - transmit bits move only on master clocks
// RULE7 - continuous enable controls reception; single ignored
// RULE8 - full word to data register, flag, interrupt
// RULE9 - only slave mode shifts while asleep
// RULE10 - both shifters run from external clock pin
// RULE11 - software empties receive buffer before sleep
// RULE12 - software fills both transmit stages before sleep
// RULE13 - holding write clears flag, waits for shifter
// RULE14 - clearing continuous or port enable clears overrun
// RULE15 - ninth received bit read before low byte
// RULE16 - nine bit transmit uses stored ninth bit
// RULE17 - clock source picks master or slave
// RULE18 - mode bit picks synchronous or asynchronous
// RULE19 - break request is async only, inert here
// RULE20 - high baud select ignored in synchronous mode
// RULE21 - shifter empty status, reset value one
// RULE22 - receive enables override transmit enable
// RULE23 - change on leading edge, sample trailing
// RULE24 - two deep buffer, third char sets overrun
module sync_serial_slave_port #(
   parameter int RX_DEPTH = 2
) (
   // clock, reset, enable
   input  wire logic        I_CLK,
   input  wire logic        I_RST,
   input  wire logic        I_CE,
   // ahb-lite slave
   input  wire logic        I_HSEL,
   input  wire logic [31:0] I_HADDR,
   input  wire logic [1:0]  I_HTRANS,
   input  wire logic        I_HWRITE,
   input  wire logic [2:0]  I_HSIZE,
   input  wire logic [31:0] I_HWDATA,
   input  wire logic        I_HREADY,
   output logic             O_HREADYOUT,
   output logic             O_HRESP,
   output logic [31:0]      O_HRDATA,
   // serial clock pin, input only in slave mode
   input  wire logic        I_SCK,
   // serial data pin
   input  wire logic        I_DT,
   output logic             O_DT_OUT,
   output logic             O_DT_OE,
   // interrupt requests and wake
   output logic             O_TX_IRQ,
   output logic             O_RX_IRQ,
   output logic             O_WAKE
);

   localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;

   if (RX_DEPTH < 1 || RX_DEPTH > 16) begin : g_bad_depth
      $error("RX_DEPTH must lie in 1..16");
   end

   // =================================================================
   // declarations
   logic [7:0]                 txcs;
   logic [7:0]                 rccs;
   logic [7:0]                 irqen;
   logic [13:0]                addr_q;
   logic                       wr_pend;
   logic                       rd_wait;
   logic                       addr_ph;
   logic [7:0]                 rd_val;
   logic                       wr_txcs;
   logic                       wr_rccs;
   logic                       wr_txd;
   logic                       wr_irq;
   logic                       rd_rxd;
   logic                       port_on;
   logic                       cont_rx;
   sync_slave_pkg::port_mode_t port_mode;
   logic                       slave_mode;
   logic                       tx_go;
   logic                       rx_go;
   logic                       sck_q;
   logic                       sck_rise;
   logic                       sck_fall;
   logic [7:0]                 thr;
   logic                       thr_full;
   sync_slave_pkg::char_t      tx_sreg;
   logic [3:0]                 tx_left;
   logic                       tx_busy;
   logic                       load;
   logic                       txif;
   sync_slave_pkg::char_t      rx_sreg;
   sync_slave_pkg::char_t      next_rx_sreg;
   logic [3:0]                 rx_cnt;
   logic [3:0]                 rx_bits;
   logic                       rx_done;
   sync_slave_pkg::char_t      rx_word;
   sync_slave_pkg::char_t      fifo [RX_DEPTH];
   logic [PW-1:0]              wr_ptr;
   logic [PW-1:0]              rd_ptr;
   logic [PW:0]                count;
   logic                       full;
   logic                       empty;
   logic                       push;
   logic                       pop;
   logic                       ovr_set;
   logic                       overrun;

   // =================================================================
   // ahb-lite: writes take no wait, reads one wait state so that the
   // answer comes from a flop and sees the previous write
   assign addr_ph     = I_HSEL & I_HTRANS[1] & I_HREADY;
   assign O_HREADYOUT = ~rd_wait;
   assign O_HRESP     = 1'b0;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         addr_q  <= 14'h0000;
         wr_pend <= 1'b0;
         rd_wait <= 1'b0;
      end else if (I_CE) begin
         wr_pend <= addr_ph & I_HWRITE
                  & (I_HADDR[31:14] == `ADDR_HI_ZERO);
         rd_wait <= addr_ph & ~I_HWRITE;
         if (addr_ph) begin
            // unmapped high addresses decode to an unused word
            addr_q <= (I_HADDR[31:14] == `ADDR_HI_ZERO)
                    ? I_HADDR[13:0] : 14'h0001;
         end
      end
   end

   assign wr_txcs = wr_pend & (addr_q == `REG_ADDR(`TXCS_IDX));
   assign wr_rccs = wr_pend & (addr_q == `REG_ADDR(`RCCS_IDX));
   assign wr_txd  = wr_pend & (addr_q == `REG_ADDR(`TXDATA_IDX));
   assign wr_irq  = wr_pend & (addr_q == `REG_ADDR(`IRQEN_IDX));
   assign rd_rxd  = rd_wait & (addr_q == `REG_ADDR(`RXDATA_IDX));

   always_comb begin
      rd_val = 8'h00;
      if (addr_q == `REG_ADDR(`TXCS_IDX)) begin
         rd_val = {txcs[7:2], ~tx_busy, txcs[0]}; // RULE21
      end else if (addr_q == `REG_ADDR(`RCCS_IDX)) begin
         // ninth bit of the top character, read before the low byte
         rd_val = {rccs[7:4], 2'b00, overrun, fifo[rd_ptr][8]}; // RULE15
      end else if (addr_q == `REG_ADDR(`RXDATA_IDX)) begin
         rd_val = fifo[rd_ptr][7:0]; // RULE8
      end else if (addr_q == `REG_ADDR(`IRQEN_IDX)) begin
         rd_val = {2'b00, ~empty, txif, 1'b0, irqen[2:0]};
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_HRDATA <= 32'h00000000;
      end else if (I_CE && rd_wait) begin
         O_HRDATA <= {24'h000000, rd_val};
      end
   end

   // =================================================================
   // control registers
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         txcs <= `TXCS_RST; // RULE21
      end else if (I_CE && wr_txcs) begin
         // break request and high baud only act in async framing
         txcs <= (I_HWDATA[7:0] & `TXCS_WMASK)
               | (txcs & ~`TXCS_WMASK); // RULE19 RULE20
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         rccs <= `RCCS_RST;
      end else if (I_CE && wr_rccs) begin
         rccs <= I_HWDATA[7:0] & `RCCS_WMASK;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         irqen <= `IRQEN_RST;
      end else if (I_CE && wr_irq) begin
         irqen <= I_HWDATA[7:0] & `IRQEN_WMASK;
      end
   end

   // =================================================================
   // mode decode
   assign port_on = rccs[`RCCS_PORT];
   assign cont_rx = rccs[`RCCS_CONT];

   always_comb begin
      if (!port_on) begin
         port_mode = sync_slave_pkg::PORT_OFF;
      end else if (!txcs[`TXCS_SYNC] || txcs[`TXCS_CLKSRC]) begin
         // async or clock master: engines not in this block
         port_mode = sync_slave_pkg::PORT_OTHER; // RULE17 RULE18
      end else if (rccs[`RCCS_ONCE] || cont_rx) begin
         port_mode = sync_slave_pkg::PORT_SLAVE_RX; // RULE2 RULE22
      end else begin
         port_mode = sync_slave_pkg::PORT_SLAVE_TX; // RULE2
      end
   end

   // outside slave mode nothing shifts, asleep or awake
   assign slave_mode = (port_mode == sync_slave_pkg::PORT_SLAVE_RX)
                     | (port_mode == sync_slave_pkg::PORT_SLAVE_TX);
   assign tx_go = (port_mode == sync_slave_pkg::PORT_SLAVE_TX)
                & txcs[`TXCS_TXON]; // RULE1 RULE9
   // single receive enable only selects direction, never starts
   assign rx_go = (port_mode == sync_slave_pkg::PORT_SLAVE_RX)
                & cont_rx & ~overrun; // RULE1 RULE7 RULE24

   // =================================================================
   // external clock edges; the pin is synchronous to I_CLK
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         sck_q <= 1'b0;
      end else if (I_CE) begin
         sck_q <= I_SCK;
      end
   end

   assign sck_rise = I_SCK & ~sck_q; // RULE10
   assign sck_fall = ~I_SCK & sck_q; // RULE10

   // =================================================================
   // transmit holding register
   assign tx_busy  = (tx_left != 4'h0);
   assign load     = tx_go & thr_full & ~tx_busy; // RULE3 RULE4
   assign txif     = ~thr_full; // RULE4 RULE13

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         thr      <= 8'h00;
         thr_full <= 1'b0;
      end else if (I_CE) begin
         if (wr_txd) begin
            thr      <= I_HWDATA[7:0]; // RULE13
            thr_full <= 1'b1; // RULE13
         end else if (load || !port_on) begin
            thr_full <= 1'b0; // RULE4
         end
      end
   end

   // =================================================================
   // transmit shifter: drive on the leading edge, count on trailing
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         tx_sreg  <= 9'h000;
         tx_left  <= 4'h0;
         O_DT_OUT <= 1'b0;
      end else if (I_CE) begin
         if (!port_on) begin
            tx_left  <= 4'h0; // RULE14
            O_DT_OUT <= 1'b0;
         end else if (load) begin
            tx_sreg <= {txcs[`TXCS_NINTH], thr}; // RULE16
            tx_left <= txcs[`TXCS_NINE] ? `BITS9 : `BITS8; // RULE16
         end else if (tx_go && tx_busy) begin
            if (sck_rise) begin
               O_DT_OUT <= tx_sreg[0]; // RULE6 RULE23
               tx_sreg  <= {1'b0, tx_sreg[8:1]};
            end else if (sck_fall) begin
               tx_left <= tx_left - 4'h1; // RULE23
            end
         end
      end
   end

   assign O_DT_OE = tx_go;

   // =================================================================
   // receive shifter: sample on the trailing edge
   assign rx_bits      = rccs[`RCCS_NINE] ? `BITS9 : `BITS8;
   assign next_rx_sreg = {I_DT, rx_sreg[8:1]};

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         rx_sreg <= 9'h000;
         rx_cnt  <= 4'h0;
         rx_done <= 1'b0;
         rx_word <= 9'h000;
      end else if (I_CE) begin
         rx_done <= 1'b0;
         if (!rx_go) begin
            // a partial character is dropped
            rx_cnt <= 4'h0; // RULE7
         end else if (sck_fall) begin
            rx_sreg <= next_rx_sreg; // RULE10 RULE23
            if (rx_cnt + 4'h1 == rx_bits) begin
               rx_cnt  <= 4'h0;
               rx_done <= 1'b1; // RULE8
               rx_word <= rccs[`RCCS_NINE] ? next_rx_sreg
                        : {1'b0, next_rx_sreg[8:1]};
            end else begin
               rx_cnt <= rx_cnt + 4'h1;
            end
         end
      end
   end

   // =================================================================
   // receive buffer
   assign full    = (count == (PW+1)'(RX_DEPTH));
   assign empty   = (count == '0);
   assign push    = rx_done & ~full; // RULE8
   assign ovr_set = rx_done & full; // RULE24
   assign pop     = rd_rxd & ~empty & I_CE;

   always_ff @(posedge I_CLK) begin
      if (I_CE && push) begin
         fifo[wr_ptr] <= rx_word; // RULE8
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (I_CE) begin
         if (!port_on) begin
            wr_ptr <= '0; // RULE14
            rd_ptr <= '0;
            count  <= '0;
         end else begin
            if (push) begin
               wr_ptr <= (wr_ptr == PW'(RX_DEPTH-1))
                       ? '0 : wr_ptr + PW'(1);
            end
            if (pop) begin
               rd_ptr <= (rd_ptr == PW'(RX_DEPTH-1))
                       ? '0 : rd_ptr + PW'(1);
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
         end
      end
   end

   // overrun set wins over a clear in the same cycle
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         overrun <= 1'b0;
      end else if (I_CE) begin
         if (ovr_set) begin
            overrun <= 1'b1; // RULE24
         end else if (!cont_rx || !port_on) begin
            overrun <= 1'b0; // RULE14
         end
      end
   end

   // =================================================================
   // interrupt requests, usable as wake from sleep
   assign O_TX_IRQ = txif & irqen[`IRQEN_PERI]
                   & irqen[`IRQEN_TXIE]; // RULE5
   assign O_RX_IRQ = ~empty & irqen[`IRQEN_RCIE]; // RULE8
   assign O_WAKE   = O_TX_IRQ | O_RX_IRQ; // RULE5 RULE8

   // =================================================================
   // checks
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST || !I_CE);

   rx_dir_a: assert property ( // RULE2
      (rccs[`RCCS_ONCE] || cont_rx) |-> !O_DT_OE)
      else $error("data pin driven in receive direction");
   tx_load_a: assert property ( // RULE3
      load && !wr_txd |=> tx_busy && !thr_full
         && (tx_left == (txcs[`TXCS_NINE] ? `BITS9 : `BITS8)))
      else $error("holding char not moved to shifter");
   txif_set_a: assert property ( // RULE4
      $rose(txif) |-> $past(load) || $past(!port_on))
      else $error("transmit flag set without reload");
   tx_irq_a: assert property ( // RULE5
      $rose(txif) && irqen[`IRQEN_PERI] && irqen[`IRQEN_TXIE]
         |-> O_TX_IRQ && O_WAKE)
      else $error("transmit wake missing");
   dt_edge_a: assert property ( // RULE6
      $changed(O_DT_OUT) |-> $past(sck_rise) || $past(!port_on))
      else $error("data changed off leading edge");
   rx_ctl_a: assert property ( // RULE7
      !cont_rx |=> rx_cnt == 4'h0 && !rx_done)
      else $error("receive ran without continuous enable");
   rx_push_a: assert property ( // RULE8
      rx_done && !full && !pop && port_on
         |=> count == $past(count) + 1'b1 ##0 !empty)
      else $error("received word not stored");
   other_mode_a: assert property ( // RULE9
      !slave_mode |=> $stable(rx_sreg) && $stable(tx_left) || !port_on)
      else $error("shifting outside slave mode");
   wr_txif_a: assert property ( // RULE13
      wr_txd |=> !txif)
      else $error("holding write did not clear flag");
   ovr_a: assert property ( // RULE24
      ovr_set |=> overrun ##1 !rx_done [*2])
      else $error("overrun not flagged or not blocking");
   ovr_clr_a: assert property ( // RULE14
      !cont_rx && !ovr_set |=> !overrun)
      else $error("overrun not cleared");
   ahb_rd_a: assert property (
      addr_ph && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT)
      else $error("read answer not one wait state");

   tx_load_c: cover property (load ##1 thr_full);
   ovr_c: cover property (ovr_set);
   rx9_c: cover property (push && rccs[`RCCS_NINE]);
   wake_c: cover property ($rose(O_WAKE));

endmodule : sync_serial_slave_port

// ==== testbench/sync_master_model.sv ====
// external synchronous master that clocks characters through the port
`timescale 1ns/1ns
module sync_master_model (
   // system clock used to pace the serial clock
   input  wire logic clk,
   // serial clock and data towards the port
   output logic      sck,
   output logic      dt,
   // data pin as driven by the port
   input  wire logic dt_out,
   input  wire logic dt_oe
);
   // =================================================================
   // idle state: clock stands low between frames
   initial begin
      sck = 1'b0;
      dt  = 1'b0;
   end

   // =================================================================
   // one frame: nbits clocks only, lsb first, 4 cycles high, 5 low between bits
   task automatic xfer(input int nbits, input logic [8:0] tx,
                       output logic [8:0] rx);
      int i;
      rx = 9'h000;
      for (i = 0; i < nbits; i++) begin
         @(posedge clk);
         sck <= 1'b1;
         dt  <= tx[i];
         repeat (4) @(posedge clk);
         // sample at the trailing edge; an undriven pin counts as z
         rx[i] = (dt_oe === 1'b1) ? dt_out : 1'bz;
         sck <= 1'b0;
         repeat (4) @(posedge clk);
      end
      // released line must not keep showing the last bit
      dt <= ~dt;
   endtask : xfer
endmodule : sync_master_model

// ==== testbench/sync_serial_slave_port_tb.sv ====
// self-checking bench for the synchronous slave serial port
`timescale 1ns/1ns
`include "sync_slave_defs.svh"
`define CHK(what, exp, got) \
   begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("unexpected %s exp %h got %h", what, exp, got); end end
module sync_serial_slave_port_tb;
   // =================================================================
   // signals
   logic        I_CLK, I_RST, I_CE, I_HSEL, I_HWRITE, I_HREADY;
   logic [31:0] I_HADDR, I_HWDATA, O_HRDATA;
   logic [1:0]  I_HTRANS;
   logic [2:0]  I_HSIZE;
   logic        O_HREADYOUT, O_HRESP, I_SCK, I_DT, O_DT_OUT, O_DT_OE;
   logic        O_TX_IRQ, O_RX_IRQ, O_WAKE;
   logic [8:0]  rx;
   int          error_cnt, total_checks;

   assign I_HREADY = O_HREADYOUT;

   sync_serial_slave_port i_sync_serial_slave_port (
      .I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_HSEL(I_HSEL),
      .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
      .I_HSIZE(I_HSIZE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY),
      .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_HRDATA(O_HRDATA),
      .I_SCK(I_SCK), .I_DT(I_DT), .O_DT_OUT(O_DT_OUT), .O_DT_OE(O_DT_OE),
      .O_TX_IRQ(O_TX_IRQ), .O_RX_IRQ(O_RX_IRQ), .O_WAKE(O_WAKE));

   sync_master_model i_sync_master_model (
      .clk(I_CLK), .sck(I_SCK), .dt(I_DT),
      .dt_out(O_DT_OUT), .dt_oe(O_DT_OE));

   // =================================================================
   // clock, 250 mhz
   initial begin
      I_CLK = 1'b0;
      forever #2 I_CLK = ~I_CLK;
   end

   // =================================================================
   // verdict
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude

   // =================================================================
   // ahb-lite single word transfer, waits on hready with a bound
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge I_CLK);
         n++;
      end while (I_HREADY !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         conclude();
      end
   endtask : wait_ready

   task automatic bus(input logic wr, input logic [11:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd);
      I_HTRANS <= 2'b10;
      I_HADDR  <= {`ADDR_HI_ZERO, `REG_ADDR(idx)};
      I_HWRITE <= wr;
      wait_ready();
      I_HTRANS <= 2'b00;
      I_HWDATA <= {24'h000000, wd};
      wait_ready();
      rd = O_HRDATA;
      `CHK("hresp", 1'b0, O_HRESP)
   endtask : bus

   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      logic [31:0] unused;
      bus(1'b1, idx, d, unused);
   endtask : wr

   task automatic rchk(input logic [11:0] idx, input logic [7:0] exp,
                       input string what);
      logic [31:0] rd;
      bus(1'b0, idx, 8'h00, rd);
      `CHK(what, {24'h000000, exp}, rd)
   endtask : rchk

   // =================================================================
   // main sequence
   initial begin
      I_RST = 1'b1; I_CE = 1'b1; I_HSEL = 1'b1; I_HWRITE = 1'b0;
      I_HTRANS = 2'b00; I_HSIZE = 3'h2; I_HADDR = 32'h00000000;
      I_HWDATA = 32'h00000000;
      error_cnt = 0;
      total_checks = 0;
      repeat (6) @(posedge I_CLK);
      I_RST <= 1'b0;
      // reset values and an unmapped place
      rchk(`TXCS_IDX, 8'h02, "txcs reset");
      rchk(`RCCS_IDX, 8'h00, "rccs reset");
      rchk(`IRQEN_IDX, 8'h10, "irq reset");
      rchk(12'h010, 8'h00, "unmapped");
      // slave transmit, two characters queued before clocks
      wr(`TXCS_IDX, 8'h30);
      wr(`RCCS_IDX, 8'h80);
      wr(`IRQEN_IDX, 8'h05);
      `CHK("dt_oe slave tx", 1'b1, O_DT_OE)
      wr(`TXDATA_IDX, 8'ha5);
      wr(`TXDATA_IDX, 8'h3c);
      repeat (2) @(posedge I_CLK);
      rchk(`TXCS_IDX, 8'h30, "txcs busy");
      rchk(`IRQEN_IDX, 8'h05, "tx flag held");
      `CHK("tx irq idle", 1'b0, O_TX_IRQ)
      i_sync_master_model.xfer(8, 9'h0a5, rx);
      `CHK("first char", 9'h0a5, rx)
      repeat (3) @(posedge I_CLK);
      `CHK("tx irq", 1'b1, O_TX_IRQ)
      `CHK("wake tx", 1'b1, O_WAKE)
      wr(`TXDATA_IDX, 8'h77);
      rchk(`IRQEN_IDX, 8'h05, "flag cleared");
      i_sync_master_model.xfer(8, 9'h000, rx);
      `CHK("second char", 9'h03c, rx)
      i_sync_master_model.xfer(8, 9'h000, rx);
      `CHK("third char", 9'h077, rx)
      repeat (3) @(posedge I_CLK);
      rchk(`TXCS_IDX, 8'h32, "txcs empty");
      // nine bit transmit, break and high baud bits inert
      wr(`TXCS_IDX, 8'h7d);
      wr(`TXDATA_IDX, 8'h5a);
      repeat (2) @(posedge I_CLK);
      i_sync_master_model.xfer(9, 9'h000, rx);
      `CHK("nine bit char", 9'h15a, rx)
      // master clock source and async mode leave the pin alone
      wr(`TXCS_IDX, 8'hb0);
      @(posedge I_CLK);
      `CHK("dt_oe master", 1'b0, O_DT_OE)
      wr(`TXCS_IDX, 8'h20);
      @(posedge I_CLK);
      `CHK("dt_oe async", 1'b0, O_DT_OE)
      // single receive enable turns the pin round but receives nothing
      wr(`TXCS_IDX, 8'h30);
      wr(`RCCS_IDX, 8'ha0);
      @(posedge I_CLK);
      `CHK("dt_oe single_receive_enable", 1'b0, O_DT_OE)
      wr(`IRQEN_IDX, 8'h02);
      i_sync_master_model.xfer(8, 9'h055, rx);
      repeat (3) @(posedge I_CLK);
      `CHK("rx irq single_receive_enable", 1'b0, O_RX_IRQ)
      // continuous receive, fill and overrun
      wr(`RCCS_IDX, 8'h90);
      i_sync_master_model.xfer(8, 9'h0c3, rx);
      repeat (3) @(posedge I_CLK);
      `CHK("rx irq", 1'b1, O_RX_IRQ)
      `CHK("wake rx", 1'b1, O_WAKE)
      i_sync_master_model.xfer(8, 9'h081, rx);
      i_sync_master_model.xfer(8, 9'h0ff, rx);
      repeat (3) @(posedge I_CLK);
      rchk(`IRQEN_IDX, 8'h32, "irq flags");
      rchk(`RCCS_IDX, 8'h92, "overrun");
      rchk(`RXDATA_IDX, 8'hc3, "rx first");
      rchk(`RXDATA_IDX, 8'h81, "rx second");
      `CHK("rx irq empty", 1'b0, O_RX_IRQ)
      wr(`RCCS_IDX, 8'h80);
      rchk(`RCCS_IDX, 8'h80, "overrun cleared");
      // nine bit receive, ninth bit read before the low byte
      wr(`RCCS_IDX, 8'hd0);
      i_sync_master_model.xfer(9, 9'h1a7, rx);
      repeat (3) @(posedge I_CLK);
      rchk(`RCCS_IDX, 8'hd1, "ninth bit");
      rchk(`RXDATA_IDX, 8'ha7, "nine bit low");
      conclude();
   end
endmodule : sync_serial_slave_port_tb
